// [core/tsa_adapter.sv]
// terminal serial adapter: line unit handshake to start/stop serial terminal link
// assumes line unit logic on clk_sys, serial_in from a pin, Avalon-MM master on clk_sys
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`include "tsa_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] serial frame: one start space, character with parity, two stop marks.
// [R2] mark is one, space is zero; idle and stop are one.
// [R3] processor side carries seven code bits plus parity, checked as elsewhere.
// [R4] seven input data lines back; eight output lines in (data plus parity).
// [R5] select: bit 7 set, bit 6 control, bit 5 write, bits 4..1 device BCD.
// [R6] device_on answers compare-address only when device number matches.
// [R7] outgoing strobe loads shift register; char_accepted follows once taken.
// [R8] request is answered by incoming strobe gating the received character.
// [R9] status reset clears fault, load and error flags.
// [R10] clear_service_request clears the service request flag.
// [R11] read, write, control give the operation; status requests status.
// [R12] printer-on code precedes every new write operation.
// [R13] device only acts on line unit requests or terminal input.
// [R14] break of a quarter second or more toggles local mode.
// [R15] start or break preloads input register ones, stop position zero.
// [R16] completed character with low last stop bit is a break.
// [R17] local holds fault set; remote block stops characters to terminal.
// [R18] entering local sends printer-on, punch-off, then left paren.
// [R19] left paren shows local, right paren shows on-line.
// [R20] leaving local: right paren at once, or after status if busy.
// [R21] write-control question mark never printed; fault status if local.
// [R22] marker at count-mode detector: parallel mode, clock stop, char ready.
// [R23] gated bit clock from build-time rate, running only per character.
module tsa_adapter #(
	parameter int BIT_CYCLES = `TSA_BIT_CYCLES,
	parameter int BREAK_CYCLES = `TSA_BREAK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// line unit
	input wire tsa_pkg::tsa_lu_in_t lu_i,
	output tsa_pkg::tsa_lu_out_t lu_o,
	// terminal link
	input wire logic serial_in,
	output logic serial_out
);
	import tsa_pkg::*;

	tsa_st_t st_ff;
	tsa_st_t nxt_st;
	logic bus_req;
	logic sel_match;
	logic wr_stb;
	logic qmark;
	logic rx_done;
	logic rx_break;
	logic [10:0] rx_shift;
	logic [31:0] rd_word;

	function automatic logic [10:0] tsa_frame(input logic [6:0] c, input logic p);
		tsa_frame = {2'b11, p, c, 1'b0};
	endfunction

	// ----------------------------------------------------------------
	// combinational decode
	// ----------------------------------------------------------------
	assign bus_req = avs_read | avs_write;
	assign sel_match = lu_i.out_data[`TSA_SEL_BIT] & (lu_i.out_data[4:1] == st_ff.dev_num); // [R5]
	assign wr_stb = st_ff.sel & lu_i.outgoing_char_strobe & ~lu_i.comp_add & lu_i.write;
	assign qmark = st_ff.op_ctl & st_ff.op_wr & (lu_i.out_data[6:0] == `TSA_CODE_QM); // [R21]
	assign rx_shift = {st_ff.s_sync, st_ff.rx_sr[10:1]};
	assign rx_done = st_ff.rx_run & (st_ff.rx_cnt == 24'h0000) & ~rx_shift[0]; // [R22]
	assign rx_break = rx_done & ~rx_shift[10]; // [R16]

	always_comb begin
		rd_word = 32'h0000_0000;
		if (avs_address == `TSA_REG_CTRL) begin
			rd_word[3:0] = st_ff.dev_num;
		end else if (avs_address == `TSA_REG_STAT) begin
			rd_word[9:0] = {st_ff.hk_wait, st_ff.in_stb, st_ff.rx_full, st_ff.tx_run,
				st_ff.sel, st_ff.service_request_flag, st_ff.error, st_ff.load,
				st_ff.fault, st_ff.local_mode};
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s_meta = serial_in;
		nxt_st.s_sync = st_ff.s_meta;
		nxt_st.acc = 1'b0;
		// bus slave, one wait cycle
		nxt_st.ack = bus_req & ~st_ff.ack;
		if (avs_read & ~st_ff.ack) begin
			nxt_st.rdata = rd_word;
		end
		if (avs_write & st_ff.ack & (avs_address == `TSA_REG_CTRL)) begin
			nxt_st.dev_num = avs_writedata[3:0];
		end
		// selection
		if (lu_i.comp_add) begin
			nxt_st.sel = sel_match; // [R6]
			nxt_st.op_ctl = lu_i.out_data[`TSA_CTL_BIT];
			nxt_st.op_wr = lu_i.out_data[`TSA_WR_BIT];
			nxt_st.need_pon = sel_match & lu_i.out_data[`TSA_WR_BIT]
				& ~lu_i.out_data[`TSA_CTL_BIT]; // [R12]
		end
		if (lu_i.status_reset) begin
			nxt_st.fault = st_ff.local_mode; // [R9] [R17]
			nxt_st.load = 1'b0;
			nxt_st.error = 1'b0;
		end
		if (lu_i.clear_service_request) begin
			nxt_st.service_request_flag = 1'b0; // [R10]
		end
		// characters from the line unit
		if (wr_stb) begin
			if (st_ff.local_mode) begin
				nxt_st.fault = 1'b1; // [R21]
			end
			if (st_ff.remote_block_flag | qmark) begin
				nxt_st.acc = 1'b1; // [R17] [R21]
			end else if (~st_ff.pend) begin
				nxt_st.pend = 1'b1; // [R7]
				nxt_st.pend_char = lu_i.out_data; // [R4]
			end
		end
		// receiver, bit clock runs only inside a character
		if (~st_ff.rx_run) begin
			if (~st_ff.s_sync & ~st_ff.brk_seen & ~st_ff.rx_full) begin
				nxt_st.rx_run = 1'b1; // [R23] [R13]
				nxt_st.rx_cnt = 24'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
				nxt_st.rx_sr = 11'b011_1111_1111; // [R15]
			end
		end else if (st_ff.rx_cnt == 24'h0000) begin
			nxt_st.rx_cnt = 24'(BIT_CYCLES - 1);
			nxt_st.rx_sr = rx_shift;
			if (rx_done) begin
				nxt_st.rx_run = 1'b0; // [R22]
				if (rx_break) begin
					nxt_st.brk_seen = 1'b1; // [R16]
					nxt_st.brk_cnt = 24'h0000;
				end else if (~st_ff.local_mode) begin
					nxt_st.rx_full = 1'b1;
					nxt_st.rx_char = rx_shift[7:1];
					if (^rx_shift[8:1]) begin
						nxt_st.error = 1'b1; // [R3]
					end
					if (rx_shift[7:1] == `TSA_CODE_STX) begin
						nxt_st.load = 1'b1;
					end
					if (rx_shift[7:1] == `TSA_CODE_ETX) begin
						nxt_st.service_request_flag = 1'b1;
					end
				end
			end
		end else begin
			nxt_st.rx_cnt = st_ff.rx_cnt - 24'h00_0001;
		end
		// break timing and local toggle
		if (st_ff.brk_seen) begin
			if (st_ff.s_sync) begin
				nxt_st.brk_seen = 1'b0;
				if (st_ff.brk_done) begin
					nxt_st.brk_done = 1'b0;
					nxt_st.hk = TSA_HK_PON; // [R18]
					nxt_st.hk_close = ~st_ff.local_mode;
					nxt_st.hk_wait = ~st_ff.local_mode & (lu_i.read | lu_i.write); // [R20]
				end
			end else if (~st_ff.brk_done) begin
				if (st_ff.brk_cnt == 24'(BREAK_CYCLES - 1)) begin
					nxt_st.brk_done = 1'b1;
					nxt_st.local_mode = ~st_ff.local_mode; // [R14]
					if (~st_ff.local_mode) begin
						nxt_st.remote_block_flag = 1'b1; // [R17]
						nxt_st.fault = 1'b1;
					end
				end else begin
					nxt_st.brk_cnt = st_ff.brk_cnt + 24'h00_0001;
				end
			end
		end
		if (st_ff.hk_wait & lu_i.status) begin
			nxt_st.hk_wait = 1'b0; // [R20]
		end
		// incoming strobe toward the line unit
		if (st_ff.in_stb) begin
			if (~lu_i.request) begin
				nxt_st.in_stb = 1'b0;
				nxt_st.rx_full = 1'b0;
			end
		end else if (st_ff.sel & lu_i.read & lu_i.request & st_ff.rx_full
			& ~st_ff.local_mode) begin
			nxt_st.in_stb = 1'b1; // [R8] [R17]
		end
		// transmitter
		if (st_ff.tx_run) begin
			if (st_ff.tx_cnt == 24'h0000) begin
				nxt_st.tx_cnt = 24'(BIT_CYCLES - 1);
				nxt_st.output_shift_reg = {1'b1, st_ff.output_shift_reg[10:1]}; // [R2]
				nxt_st.tx_bits = st_ff.tx_bits - 4'h1;
				if (st_ff.tx_bits == 4'h1) begin
					nxt_st.tx_run = 1'b0; // [R23]
					nxt_st.acc = st_ff.tx_data; // [R7]
					nxt_st.tx_data = 1'b0;
				end
			end else begin
				nxt_st.tx_cnt = st_ff.tx_cnt - 24'h00_0001;
			end
		end else if ((st_ff.hk != TSA_HK_IDLE) & ~((st_ff.hk == TSA_HK_PAREN) & st_ff.hk_wait)) begin
			nxt_st.tx_run = 1'b1; // [R18]
			nxt_st.tx_cnt = 24'(BIT_CYCLES - 1);
			nxt_st.tx_bits = `TSA_FRAME_BITS;
			unique case (st_ff.hk)
				TSA_HK_PON: begin
					nxt_st.output_shift_reg = tsa_frame(`TSA_CODE_PON, ^`TSA_CODE_PON);
					nxt_st.hk = TSA_HK_POFF;
				end
				TSA_HK_POFF: begin
					nxt_st.output_shift_reg = tsa_frame(`TSA_CODE_POFF, ^`TSA_CODE_POFF);
					nxt_st.hk = TSA_HK_PAREN;
				end
				TSA_HK_PAREN: begin
					if (st_ff.hk_close) begin
						nxt_st.output_shift_reg = tsa_frame(`TSA_CODE_RPAR, ^`TSA_CODE_RPAR); // [R19]
						nxt_st.remote_block_flag = 1'b0;
					end else begin
						nxt_st.output_shift_reg = tsa_frame(`TSA_CODE_LPAR, ^`TSA_CODE_LPAR); // [R19]
					end
					nxt_st.hk = TSA_HK_IDLE;
				end
				TSA_HK_IDLE: begin
					nxt_st.tx_run = 1'b0;
				end
			endcase
		end else if (st_ff.pend) begin
			nxt_st.tx_run = 1'b1;
			nxt_st.tx_cnt = 24'(BIT_CYCLES - 1);
			nxt_st.tx_bits = `TSA_FRAME_BITS;
			if (st_ff.need_pon) begin
				nxt_st.output_shift_reg = tsa_frame(`TSA_CODE_PON, ^`TSA_CODE_PON); // [R12]
				nxt_st.need_pon = 1'b0;
			end else begin
				nxt_st.output_shift_reg = tsa_frame(st_ff.pend_char[6:0], st_ff.pend_char[7]); // [R1]
				nxt_st.pend = 1'b0;
				nxt_st.tx_data = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.dev_num <= `TSA_DEV_RST;
			st_ff.s_meta <= 1'b1;
			st_ff.s_sync <= 1'b1;
			st_ff.output_shift_reg <= 11'h7FF;
			st_ff.hk <= TSA_HK_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_waitrequest = bus_req & ~st_ff.ack;
	assign avs_readdata = st_ff.rdata;
	assign serial_out = st_ff.output_shift_reg[0]; // [R1]
	assign lu_o.char_accepted = st_ff.acc;
	assign lu_o.device_on = lu_i.comp_add & sel_match;
	assign lu_o.fault = st_ff.fault;
	assign lu_o.incoming_char_strobe = st_ff.in_stb;
	assign lu_o.load = st_ff.load;
	assign lu_o.service_request_flag = st_ff.service_request_flag;
	assign lu_o.status_ready = st_ff.sel & lu_i.status & ~st_ff.tx_run & ~st_ff.pend; // [R11]
	assign lu_o.in_data = st_ff.rx_char; // [R4]

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_device_on_match: assert property (@(posedge clk_sys) disable iff (reset)
		lu_o.device_on |-> lu_i.out_data[7] && lu_i.out_data[4:1] == st_ff.dev_num) // [R6]
		else $error("device_on without match");
	a_local_holds_fault: assert property (@(posedge clk_sys) disable iff (reset)
		st_ff.local_mode && $past(st_ff.local_mode) |-> lu_o.fault) // [R17]
		else $error("fault dropped in local");
	a_start_bit_space: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(st_ff.tx_run) |-> !serial_out ##1 !serial_out) // [R1]
		else $error("no start space");
	a_stop_marks: assert property (@(posedge clk_sys) disable iff (reset)
		st_ff.tx_run && st_ff.tx_bits <= 4'h2 |-> serial_out) // [R2]
		else $error("stop bit not mark");
	a_pon_before_write: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(st_ff.tx_data) |-> !st_ff.need_pon) // [R12]
		else $error("write char before printer-on");
	a_service_request_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
		lu_i.clear_service_request && !rx_done |=> !lu_o.service_request_flag) // [R10]
		else $error("service request not cleared");
	a_status_clear: assert property (@(posedge clk_sys) disable iff (reset)
		lu_i.status_reset && !rx_done |=> !lu_o.load && !st_ff.error) // [R9]
		else $error("status flags not cleared");
	a_in_stb_cause: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(lu_o.incoming_char_strobe) |-> $past(lu_i.request) && !st_ff.local_mode) // [R8]
		else $error("incoming strobe without request");
	a_block_write: assert property (@(posedge clk_sys) disable iff (reset)
		wr_stb && (st_ff.remote_block_flag || qmark) |=> lu_o.char_accepted && !st_ff.pend) // [R21]
		else $error("blocked char queued");
	c_char_in: cover property (@(posedge clk_sys) $rose(lu_o.incoming_char_strobe));
	c_char_out: cover property (@(posedge clk_sys) lu_o.char_accepted);
	c_enter_local: cover property (@(posedge clk_sys) $rose(st_ff.local_mode));
endmodule

`default_nettype wire

// [core/tsa_consts.svh]
// constants of the terminal serial adapter: offsets, codes, timing
// assumes a 25 MHz system clock and word-aligned Avalon-MM byte addresses
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSA_CLK_HZ 25000000
`define TSA_BAUD 110
`define TSA_BIT_CYCLES (`TSA_CLK_HZ / `TSA_BAUD)
`define TSA_BREAK_MS 250
`define TSA_BREAK_CYCLES ((`TSA_CLK_HZ / 1000) * `TSA_BREAK_MS)

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define TSA_REG_CTRL 4'h0
`define TSA_REG_STAT 4'h4
`define TSA_DEV_RST 4'h1

// ----------------------------------------------------------------
// frame and codes
// ----------------------------------------------------------------
`define TSA_FRAME_BITS 4'hB
`define TSA_SEL_BIT 7
`define TSA_CTL_BIT 6
`define TSA_WR_BIT 5
`define TSA_CODE_PON 7'h12
`define TSA_CODE_POFF 7'h14
`define TSA_CODE_LPAR 7'h28
`define TSA_CODE_RPAR 7'h29
`define TSA_CODE_QM 7'h3F
`define TSA_CODE_STX 7'h02
`define TSA_CODE_ETX 7'h03

`endif

// [core/tsa_pkg.sv]
// types of the terminal serial adapter
// assumes tsa_consts.svh for all figures
package tsa_pkg;
	typedef enum logic [1:0] {
		TSA_HK_IDLE = 2'b00,
		TSA_HK_PON = 2'b01,
		TSA_HK_POFF = 2'b10,
		TSA_HK_PAREN = 2'b11
	} tsa_hk_t;

	typedef struct packed {
		logic comp_add;
		logic control;
		logic clear_service_request;
		logic outgoing_char_strobe;
		logic read;
		logic request;
		logic status;
		logic status_reset;
		logic write;
		logic [7:0] out_data;
	} tsa_lu_in_t;

	typedef struct packed {
		logic char_accepted;
		logic device_on;
		logic fault;
		logic incoming_char_strobe;
		logic load;
		logic service_request_flag;
		logic status_ready;
		logic [6:0] in_data;
	} tsa_lu_out_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [3:0] dev_num;
		logic s_meta;
		logic s_sync;
		logic sel;
		logic op_ctl;
		logic op_wr;
		logic need_pon;
		logic rx_run;
		logic [23:0] rx_cnt;
		logic [10:0] rx_sr;
		logic rx_full;
		logic [6:0] rx_char;
		logic brk_seen;
		logic brk_done;
		logic [23:0] brk_cnt;
		logic local_mode;
		logic remote_block_flag;
		logic fault;
		logic load;
		logic error;
		logic service_request_flag;
		logic tx_run;
		logic tx_data;
		logic [23:0] tx_cnt;
		logic [3:0] tx_bits;
		logic [10:0] output_shift_reg;
		tsa_hk_t hk;
		logic hk_close;
		logic hk_wait;
		logic pend;
		logic [7:0] pend_char;
		logic acc;
		logic in_stb;
	} tsa_st_t;
endpackage

// [test/testbench.sv]
// testbench of the terminal serial adapter: avalon, line unit and terminal traffic
// assumes tsa_pkg, tsa_adapter and tsa_term_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tsa_pkg::*;
	localparam int BITC = 8;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	tsa_lu_in_t lu = '0;
	tsa_lu_out_t lu_o;
	logic serial_in;
	logic serial_out;
	logic [31:0] rd;
	int err_count = 0;
	int samples_checked = 0;
	tsa_adapter #(.BIT_CYCLES(BITC), .BREAK_CYCLES(50)) u_tsa_adapter (
		.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .lu_i(lu), .lu_o(lu_o), .serial_in(serial_in),
		.serial_out(serial_out));
	tsa_term_model #(.BITC(BITC)) u_tsa_term_model (
		.clk_sys(clk_sys), .serial_out(serial_out), .serial_in(serial_in));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic hang;
		$display("[ERR] %0t got %h exp %h", $time, 32'h0000_0000, 32'h0000_0001);
		err_count++;
		tally_and_finish();
	endtask
	// avalon access, held until waitrequest seen low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) hang();
			@(posedge clk_sys);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// 0 accepted, 1 incoming strobe, w >= 2 at least w-1 frames queued
	function automatic logic cond(input int w);
		case (w)
			0: return lu_o.char_accepted;
			1: return lu_o.incoming_char_strobe;
			default: return u_tsa_term_model.rxq.size() >= w - 1;
		endcase
	endfunction
	task automatic wait_on(input int w, input int lim);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (cond(w) !== 1'b1) begin
			n++;
			if (n > lim) hang();
			@(negedge clk_sys);
		end
	endtask
	task automatic frm(input logic [6:0] c);
		wait_on(2, 40 * BITC);
		chk(u_tsa_term_model.rxq.pop_front(), {1'b1, ^c, c});
	endtask
	task automatic sel(input logic [7:0] c, input logic exp);
		@(posedge clk_sys);
		lu.comp_add <= 1'b1;
		lu.out_data <= c;
		lu.read <= !c[5];
		lu.write <= c[5];
		lu.control <= c[6];
		@(negedge clk_sys);
		chk(lu_o.device_on, exp);
		@(posedge clk_sys);
		lu.comp_add <= 1'b0;
		lu.status_reset <= 1'b1;
		@(posedge clk_sys);
		lu.status_reset <= 1'b0;
	endtask
	task automatic wr_char(input logic [6:0] c);
		@(posedge clk_sys);
		lu.out_data <= {^c, c};
		lu.outgoing_char_strobe <= 1'b1;
		@(posedge clk_sys);
		lu.outgoing_char_strobe <= 1'b0;
		wait_on(0, 40 * BITC);
	endtask
	task automatic rd_char(input logic [7:0] f, input logic [6:0] exp);
		u_tsa_term_model.send_char(f);
		repeat (4 * BITC) @(posedge clk_sys);
		lu.request <= 1'b1;
		wait_on(1, 100);
		chk(lu_o.in_data, exp);
		@(posedge clk_sys);
		lu.request <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(lu_o.incoming_char_strobe, 32'h0000_0000);
	endtask
	task automatic idle_chk(input logic f);
		repeat (30 * BITC) @(posedge clk_sys);
		chk(u_tsa_term_model.rxq.size(), 32'h0000_0000);
		chk(lu_o.fault, f);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		av(1'b0, 4'h0, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		av(1'b1, 4'h8, 32'hFFFF_FFFF);
		av(1'b0, 4'h8, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		av(1'b1, 4'h0, 32'h0000_0002);
		sel(8'hA4, 1'b1);
		sel(8'hA2, 1'b0);
		av(1'b1, 4'h0, 32'h0000_0001);
		sel(8'hA2, 1'b1);
		wr_char(7'h41);
		frm(7'h12);
		frm(7'h41);
		wr_char(7'h43);
		frm(7'h43);
		sel(8'hA2, 1'b1);
		wr_char(7'h41);
		frm(7'h12);
		frm(7'h41);
		sel(8'h82, 1'b1);
		rd_char(8'h35, 7'h35);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[3], 32'h0000_0000);
		rd_char(8'hB5, 7'h35);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[3], 32'h0000_0001);
		sel(8'h82, 1'b1);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[3], 32'h0000_0000);
		rd_char(8'h03, 7'h03);
		chk(lu_o.service_request_flag, 32'h0000_0001);
		@(posedge clk_sys);
		lu.clear_service_request <= 1'b1;
		@(posedge clk_sys);
		lu.clear_service_request <= 1'b0;
		@(negedge clk_sys);
		chk(lu_o.service_request_flag, 32'h0000_0000);
		u_tsa_term_model.send_break(300);
		frm(7'h12);
		frm(7'h14);
		frm(7'h28);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[0], 32'h0000_0001);
		chk(lu_o.fault, 32'h0000_0001);
		sel(8'hA2, 1'b1);
		wr_char(7'h41);
		idle_chk(1'b1);
		@(posedge clk_sys);
		lu.read <= 1'b0;
		lu.write <= 1'b0;
		u_tsa_term_model.send_break(300);
		frm(7'h12);
		frm(7'h14);
		frm(7'h29);
		chk(u_tsa_term_model.rxq.size(), 32'h0000_0000);
		av(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[0], 32'h0000_0000);
		sel(8'hE2, 1'b1);
		wr_char(7'h3F);
		idle_chk(1'b0);
		@(posedge clk_sys);
		lu.status <= 1'b1;
		@(negedge clk_sys);
		chk(lu_o.status_ready, 32'h0000_0001);
		@(posedge clk_sys);
		lu.status <= 1'b0;
		idle_chk(1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [test/tsa_term_model.sv]
// terminal model: decodes frames on serial_out, sends characters and breaks on serial_in
// assumes one clk_sys domain and a testbench that calls its tasks
`timescale 1ns/1ps
`default_nettype none
module tsa_term_model #(
	parameter int BITC = 8
) (
	// clock
	input wire logic clk_sys,
	// terminal link
	input wire logic serial_out,
	output logic serial_in
);
	logic [8:0] rxq[$];
	logic [10:0] fr;
	logic ok;
	initial serial_in = 1'b1;
	// ----------------------------------------------------------------
	// receiver: mid-bit samples, queue holds {frame ok, parity, code}
	// ----------------------------------------------------------------
	initial begin
		forever begin
			@(negedge serial_out);
			repeat (BITC / 2) @(negedge clk_sys);
			for (int i = 0; i < 11; i++) begin
				fr[i] = serial_out;
				if (i < 10) repeat (BITC) @(negedge clk_sys);
			end
			ok = !fr[0] && fr[9] && fr[10];
			rxq.push_back({ok, fr[8:1]});
		end
	end
	// ----------------------------------------------------------------
	// sender: start space, code lsb first, parity, two stop marks
	// ----------------------------------------------------------------
	task automatic send_char(input logic [7:0] c);
		logic [10:0] f;
		f = {2'b11, c, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_sys);
			serial_in <= f[i];
			repeat (BITC - 1) @(posedge clk_sys);
		end
	endtask
	task automatic send_break(input int n);
		@(posedge clk_sys);
		serial_in <= 1'b0;
		repeat (n) @(posedge clk_sys);
		serial_in <= 1'b1; // idle mark after release
	endtask
endmodule
`default_nettype wire
